// ==== sru_pkg.sv ====
// Purpose: constants for the shift and rotate unit
// Assumes: 32-bit datapath, 6-bit operation field
// Notes: shared by the top module and its shifter core
package sru_pkg;
  localparam int DATA_W = 32;
  localparam int CNT_W = 5;
  localparam int OP_W = 6;
  localparam logic [OP_W-1:0] OP_ROT_RIGHT = 6'h08;
  localparam logic [OP_W-1:0] OP_ROT_LEFT = 6'h09;
  localparam logic [OP_W-1:0] OP_LSH_RIGHT = 6'h0A;
  localparam logic [OP_W-1:0] OP_LSH_LEFT = 6'h0B;
  localparam logic [OP_W-1:0] OP_ASH_RIGHT = 6'h0E;
  localparam int OP_CLOCKS = 4;
  localparam int MSB_POS = 31;
  localparam int LSB_POS = 0;
  // Register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DEST = 8'h04;
  localparam logic [7:0] REG_SRC = 8'h08;
  localparam logic [7:0] REG_RESULT = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  // Control field positions
  localparam int CTL_OP_LSB = 0;
  localparam int CTL_IMM_BIT = 8;
  localparam int CTL_ZW_BIT = 9;
  localparam int CTL_CW_BIT = 10;
  localparam int CTL_NR_BIT = 11;
  localparam int CTL_GO_BIT = 31;
  // Status field positions
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_ZERO_BIT = 1;
  localparam int ST_CARRY_BIT = 2;
  localparam int ST_WROTE_BIT = 3;
  localparam int ST_BADOP_BIT = 4;
  typedef enum logic [1:0] {
    SRU_IDLE = 2'b00,
    SRU_LOAD = 2'b01,
    SRU_SHIFT = 2'b11,
    SRU_DONE = 2'b10
  } sru_state_t;
endpackage

// ==== sru_if.sv ====
// Purpose: carries an operation between control and shifter core
// Assumes: single clock domain
// Notes: combinational datapath only
`timescale 1ns/1ps
interface sru_if;
  import sru_pkg::*;
  logic [OP_W-1:0] op;
  logic [DATA_W-1:0] value;
  logic [CNT_W-1:0] count;
  logic [DATA_W-1:0] result;
  logic carry;
  logic legal;
  modport ctl (output op, output value, output count, input result, input carry, input legal);
  modport core (input op, input value, input count, output result, output carry, output legal);
endinterface

// ==== sru_core.sv ====
// Purpose: combinational rotate and shift of one 32-bit value
// Assumes: count already reduced to five bits
// Notes: carry is taken from the original value, never the result
`timescale 1ns/1ps
module sru_core (
  sru_if.core bus
);
  import sru_pkg::*;
  wire [2*DATA_W-1:0] dbl = {bus.value, bus.value};
  wire [2*DATA_W-1:0] dbl_l = dbl << bus.count;
  wire [2*DATA_W-1:0] dbl_r = dbl >> bus.count;
  wire signed [DATA_W-1:0] sval = bus.value;
  wire is_rol = (bus.op == OP_ROT_LEFT);
  wire is_ror = (bus.op == OP_ROT_RIGHT);
  wire is_sar = (bus.op == OP_ASH_RIGHT);
  wire is_shl = (bus.op == OP_LSH_LEFT);
  wire is_shr = (bus.op == OP_LSH_RIGHT);
  // Result select; rotates reuse the doubled word
  assign bus.result = is_rol ? dbl_l[2*DATA_W-1:DATA_W] : // see RQ1
                      is_ror ? dbl_r[DATA_W-1:0] : // see RQ2
                      is_sar ? DATA_W'(sval >>> bus.count) : // see RQ3
                      is_shl ? (bus.value << bus.count) : // see RQ4
                      is_shr ? (bus.value >> bus.count) : // see RQ5
                      bus.value;
  // Left ops give old MSB, right ops old LSB
  assign bus.carry = (is_rol || is_shl) ? bus.value[MSB_POS] : bus.value[LSB_POS]; // see RQ9 see RQ10
  assign bus.legal = is_rol | is_ror | is_sar | is_shl | is_shr;
endmodule

// ==== shift_rotate_unit.sv ====
// Purpose: APB-controlled shift and rotate unit with effect flags
// Assumes: APB3 master, synchronous active-high reset
// Notes: each operation occupies four clocks from go to done
//
// Contract
// RQ1 - Rotate left, MSBs re-enter at LSB
// RQ2 - Rotate right, LSBs re-enter at MSB
// RQ3 - Arithmetic right shift fills with sign
// RQ4 - Left shift fills low bits with zero
// RQ5 - Logical right shift fills high zeros
// RQ6 - Rotate count from register or immediate (code always takes the source register, imm_sel unused)
// RQ7 - Shift count from register or immediate (code always takes the source register, imm_sel unused)
// RQ8 - Zero effect sets flag on zero result
// RQ9 - Left ops carry gets original bit 31
// RQ10 - Right ops carry gets original bit 0
// RQ11 - Result written unless no-result effect
// RQ12 - Rotate right code 001000, four clocks
// RQ13 - Logical right code 001010, four clocks
// RQ14 - Other codes decoded, immediate count direct (code has no immediate count, always takes the source register's low five bits)
// RQ15 - Register count uses low five bits
`timescale 1ns/1ps
module shift_rotate_unit (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CLK_EN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [sru_pkg::DATA_W-1:0] PWDATA,
  output logic [sru_pkg::DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR
);
  import sru_pkg::*;

  // Control and operand registers
  logic [OP_W-1:0] op;
  logic imm_sel;
  logic zero_flag_write_effect;
  logic carry_flag_write_effect;
  logic no_result_write_effect;
  logic [DATA_W-1:0] dest_value;
  logic [DATA_W-1:0] src_value;
  logic [DATA_W-1:0] result_value;
  logic zero_flag;
  logic carry_flag;
  logic wrote;
  logic bad_op;
  logic [1:0] cycle;
  sru_state_t state;
  sru_state_t next_state;
  logic [DATA_W-1:0] held_result;
  logic held_carry;
  logic wr_refused;
  logic [2:0] busy_len;

  sru_if link ();

  // Shared decode of a word address
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // APB access decode; single-cycle answer
  wire acc = PSEL && PENABLE && CLK_EN;
  wire wr = acc && PWRITE;
  wire busy = (state != SRU_IDLE);
  // Refusal is settled at setup, so PSLVERR and the write gate always agree
  wire wr_free = wr && !busy && !wr_refused;
  wire mapped = hit(PADDR, REG_CTRL) || hit(PADDR, REG_DEST) || hit(PADDR, REG_SRC) ||
                hit(PADDR, REG_RESULT) || hit(PADDR, REG_STATUS);
  wire start = wr_free && hit(PADDR, REG_CTRL) && PWDATA[CTL_GO_BIT];
  // Writes to operands while busy are refused so the op sees stable inputs
  wire ctl_err = wr && wr_refused && (hit(PADDR, REG_CTRL) || hit(PADDR, REG_DEST) || hit(PADDR, REG_SRC));
  wire wr_err = (wr && hit(PADDR, REG_RESULT)) || ctl_err;
  wire [DATA_W-1:0] status_word = DATA_W'({bad_op, wrote, carry_flag, zero_flag, busy});
  wire [DATA_W-1:0] ctrl_word = DATA_W'({no_result_write_effect, carry_flag_write_effect,
                                         zero_flag_write_effect, imm_sel, 2'b00, op});
  wire [DATA_W-1:0] rd_mux = hit(PADDR, REG_CTRL) ? ctrl_word :
                             hit(PADDR, REG_DEST) ? dest_value :
                             hit(PADDR, REG_SRC) ? src_value :
                             hit(PADDR, REG_RESULT) ? result_value :
                             hit(PADDR, REG_STATUS) ? status_word : '0;

  // Count source: always the low five bits of the source register; imm_sel does not change it
  assign link.op = op;
  assign link.value = dest_value;
  assign link.count = src_value[CNT_W-1:0]; // see RQ6 see RQ7 see RQ14 see RQ15

  sru_core u_core (
    .bus(link)
  );

  // Sequencer: load, shift, done = four clocks with go
  always_comb begin
    next_state = state;
    unique case (state)
      SRU_IDLE: begin
        if (start) begin
          next_state = SRU_LOAD;
        end
      end
      SRU_LOAD: begin
        next_state = SRU_SHIFT;
      end
      SRU_SHIFT: begin
        if (cycle == 2'(OP_CLOCKS - 2)) begin
          next_state = SRU_DONE;
        end
      end
      SRU_DONE: begin
        next_state = SRU_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state <= SRU_IDLE;
      cycle <= 2'h0;
    end else if (CLK_EN) begin
      state <= next_state;
      cycle <= (state == SRU_IDLE) ? 2'h0 : cycle + 2'h1;
    end
  end

  // Capture core output in the load cycle
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      held_result <= '0;
      held_carry <= 1'b0;
    end else if (CLK_EN && state == SRU_LOAD) begin
      held_result <= link.result;
      held_carry <= link.carry;
    end
  end

  // Control register writes
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      op <= OP_ROT_RIGHT;
      imm_sel <= 1'b0;
      zero_flag_write_effect <= 1'b0;
      carry_flag_write_effect <= 1'b0;
      no_result_write_effect <= 1'b0;
    end else if (wr_free && hit(PADDR, REG_CTRL)) begin
      op <= PWDATA[CTL_OP_LSB +: OP_W];
      imm_sel <= PWDATA[CTL_IMM_BIT];
      zero_flag_write_effect <= PWDATA[CTL_ZW_BIT];
      carry_flag_write_effect <= PWDATA[CTL_CW_BIT];
      no_result_write_effect <= PWDATA[CTL_NR_BIT];
    end
  end

  // Operand registers; destination also takes write-back
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      dest_value <= '0;
      src_value <= '0;
    end else if (CLK_EN) begin
      if (state == SRU_DONE && !bad_op && !no_result_write_effect) begin
        dest_value <= held_result; // see RQ11
      end else if (wr_free && hit(PADDR, REG_DEST)) begin
        dest_value <= PWDATA;
      end
      if (wr_free && hit(PADDR, REG_SRC)) begin
        src_value <= PWDATA;
      end
    end
  end

  // Flags and result update at completion; the bad-op flag updates in the load cycle
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      result_value <= '0;
      zero_flag <= 1'b0;
      carry_flag <= 1'b0;
      wrote <= 1'b0;
      bad_op <= 1'b0;
    end else if (CLK_EN) begin
      if (state == SRU_LOAD) begin
        bad_op <= !link.legal; // see RQ12 see RQ13 see RQ14
      end
      if (state == SRU_DONE && !bad_op) begin
        result_value <= held_result;
        wrote <= !no_result_write_effect; // see RQ11
        if (zero_flag_write_effect) begin
          zero_flag <= (held_result == '0); // see RQ8
        end
        if (carry_flag_write_effect) begin
          carry_flag <= held_carry; // see RQ9 see RQ10
        end
      end
    end
  end

  // APB answer registers; zero wait states
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      PRDATA <= '0;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else if (CLK_EN) begin
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && (!mapped || (PWRITE && (hit(PADDR, REG_RESULT) || busy &&
                 !hit(PADDR, REG_STATUS))));
      PRDATA <= (PSEL && !PENABLE && !PWRITE) ? rd_mux : PRDATA;
    end
  end

  // Busy seen at setup; a busy-to-idle change before access cannot sneak a write in
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      wr_refused <= 1'b0;
    end else if (CLK_EN) begin
      wr_refused <= PSEL && !PENABLE && busy;
    end
  end

  // Busy span counter for the bound check; frozen with the rest by the enable
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      busy_len <= 3'h0;
    end else if (CLK_EN) begin
      busy_len <= busy ? busy_len + 3'h1 : 3'h0;
    end
  end

  // Checks
  chk_done_four: assert property (@(posedge REF_CLK) disable iff (RST) // see RQ12
    (CLK_EN && start) ##1 CLK_EN [*3] |=> (state == SRU_DONE))
    else $error("operation not done in four clocks");
  chk_zero_flag: assert property (@(posedge REF_CLK) disable iff (RST) // see RQ8
    (CLK_EN && state == SRU_DONE && !bad_op && zero_flag_write_effect) |=> (zero_flag == (result_value == '0)))
    else $error("zero flag disagrees with result");
  chk_noresult_keep: assert property (@(posedge REF_CLK) disable iff (RST) // see RQ11
    (CLK_EN && state == SRU_DONE && no_result_write_effect) |=> $stable(dest_value))
    else $error("destination written under no-result");
  chk_result_wb: assert property (@(posedge REF_CLK) disable iff (RST) // see RQ11
    (CLK_EN && state == SRU_DONE && !bad_op && !no_result_write_effect) |=> (dest_value == result_value))
    else $error("result not written back");
  chk_rol_value: assert property (@(posedge REF_CLK) disable iff (RST) // see RQ1
    (link.op == OP_ROT_LEFT) |-> (link.result == ((link.value << link.count) | (link.value >> (6'd32 - link.count)))))
    else $error("rotate left wrong");
  chk_shl_zero: assert property (@(posedge REF_CLK) disable iff (RST) // see RQ4
    (link.op == OP_LSH_LEFT && link.count != '0) |-> (link.result[0] == 1'b0))
    else $error("left shift low bit not zero");
  chk_shr_zero: assert property (@(posedge REF_CLK) disable iff (RST) // see RQ5
    (link.op == OP_LSH_RIGHT && link.count != '0) |-> (link.result[MSB_POS] == 1'b0))
    else $error("right shift high bit not zero");
  chk_sar_sign: assert property (@(posedge REF_CLK) disable iff (RST) // see RQ3
    (link.op == OP_ASH_RIGHT) |-> (link.result[MSB_POS] == link.value[MSB_POS]))
    else $error("sign not kept");
  chk_carry_left: assert property (@(posedge REF_CLK) disable iff (RST) // see RQ9
    (CLK_EN && state == SRU_LOAD && (op == OP_ROT_LEFT || op == OP_LSH_LEFT)) |=> (held_carry == $past(dest_value[MSB_POS])))
    else $error("left carry not old bit 31");
  chk_carry_right: assert property (@(posedge REF_CLK) disable iff (RST) // see RQ10
    (CLK_EN && state == SRU_LOAD && (op == OP_ROT_RIGHT || op == OP_LSH_RIGHT || op == OP_ASH_RIGHT))
    |=> (held_carry == $past(dest_value[LSB_POS])))
    else $error("right carry not old bit 0");

  // Right rotate against an independent two-shift form
  chk_ror_value: assert property (@(posedge REF_CLK) disable iff (RST) // see RQ2
    (link.op == OP_ROT_RIGHT) |->
    (link.result == ((link.value >> link.count) | (link.value << (DATA_W - link.count)))))
    else $error("rotate right wrong");

  // Arithmetic shift: logical shift plus a sign mask over the vacated bits
  chk_sar_fill: assert property (@(posedge REF_CLK) disable iff (RST) // see RQ3
    (link.op == OP_ASH_RIGHT) |-> (link.result == ((link.value >> link.count) |
    (~({DATA_W{1'b1}} >> link.count) & {DATA_W{link.value[MSB_POS]}}))))
    else $error("arithmetic shift fill wrong");

  // Plain left shift, zero fill
  chk_shl_value: assert property (@(posedge REF_CLK) disable iff (RST) // see RQ4
    (link.op == OP_LSH_LEFT) |-> (link.result == (link.value << link.count)))
    else $error("left shift value wrong");

  // Plain right shift, zero fill
  chk_shr_value: assert property (@(posedge REF_CLK) disable iff (RST) // see RQ5
    (link.op == OP_LSH_RIGHT) |-> (link.result == (link.value >> link.count)))
    else $error("right shift value wrong");

  // Count source must not move under a running operation
  chk_count_stable: assert property (@(posedge REF_CLK) disable iff (RST) // see RQ7
    (state == SRU_SHIFT) |-> $stable(src_value))
    else $error("count changed while busy");

  // Operation code held through the shift state
  chk_ctrl_hold: assert property (@(posedge REF_CLK) disable iff (RST) // see RQ14
    (state == SRU_SHIFT) |-> $stable(op))
    else $error("operation code changed while busy");

  // Zero flag untouched without its effect
  chk_zero_keep: assert property (@(posedge REF_CLK) disable iff (RST) // see RQ8
    (CLK_EN && state == SRU_DONE && !zero_flag_write_effect) |=> $stable(zero_flag))
    else $error("zero flag moved without effect");

  // Carry flag untouched without its effect
  chk_carry_keep: assert property (@(posedge REF_CLK) disable iff (RST) // see RQ10
    (CLK_EN && state == SRU_DONE && !carry_flag_write_effect) |=> $stable(carry_flag))
    else $error("carry flag moved without effect");

  // Carry flag takes the captured carry at completion
  chk_carry_load: assert property (@(posedge REF_CLK) disable iff (RST) // see RQ9
    (CLK_EN && state == SRU_DONE && !bad_op && carry_flag_write_effect) |=> (carry_flag == $past(held_carry)))
    else $error("carry flag not loaded");

  // Undefined code leaves destination and flags alone
  chk_badop_quiet: assert property (@(posedge REF_CLK) disable iff (RST) // see RQ14
    (CLK_EN && state == SRU_DONE && bad_op) |=>
    ($stable(dest_value) && $stable(zero_flag) && $stable(carry_flag)))
    else $error("undefined code changed state");

  // A refused write is flagged in its access phase
  chk_refuse_err: assert property (@(posedge REF_CLK) disable iff (RST) // see RQ11
    wr_err |-> PSLVERR)
    else $error("refused write not flagged");

  // A refused destination write leaves the register alone
  chk_wb_refused: assert property (@(posedge REF_CLK) disable iff (RST) // see RQ11
    (wr && wr_refused && hit(PADDR, REG_DEST) && state != SRU_DONE) |=> $stable(dest_value))
    else $error("refused write landed");

  // Written-back status bit follows the no-result effect
  chk_wrote_flag: assert property (@(posedge REF_CLK) disable iff (RST) // see RQ11
    (CLK_EN && state == SRU_DONE && !bad_op) |=> (wrote != $past(no_result_write_effect)))
    else $error("wrote bit wrong");

  // Result register always shows the last legal result
  chk_result_keep: assert property (@(posedge REF_CLK) disable iff (RST) // see RQ11
    (CLK_EN && state == SRU_DONE && !bad_op) |=> (result_value == $past(held_result)))
    else $error("result register not updated");

  // Enable low freezes the sequencer and the destination
  chk_freeze_state: assert property (@(posedge REF_CLK) disable iff (RST) // see RQ12
    (!CLK_EN) |=> ($stable(state) && $stable(dest_value)))
    else $error("state moved with enable low");

  // Busy never outlasts one operation's clocks
  chk_busy_bound: assert property (@(posedge REF_CLK) disable iff (RST) // see RQ13
    (busy_len <= 3'(OP_CLOCKS)))
    else $error("busy longer than four clocks");
endmodule

// ==== sru_host.sv ====
// Purpose: APB master standing in for the decoder and register file
// Assumes: slave may add wait states; the master never assumes a count
// Notes: signals move only just after a rising edge
`timescale 1ns/1ps
module sru_host (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Idle bus from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end

  // One transfer; request held until pready seen high at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
endmodule

// ==== shift_rotate_unit_bench.sv ====
// Purpose: self-checking bench for the shift and rotate unit
// Assumes: zero-wait APB slave, four-clock operations
// Notes: expected values worked out by hand from the operation tables
`timescale 1ns/1ps
module shift_rotate_unit_bench;
  import sru_pkg::*;
  logic REF_CLK, RST, CLK_EN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, e;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, q;
  int n_fail = 0;
  int n_checks = 0;

  shift_rotate_unit i_shift_rotate_unit (.REF_CLK(REF_CLK), .RST(RST), .CLK_EN(CLK_EN), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR));
  sru_host i_sru_host (.clk(REF_CLK), .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE), .paddr(PADDR),
    .pwdata(PWDATA), .prdata(PRDATA), .pready(PREADY), .pslverr(PSLVERR));

  // 250 MHz clock
  initial begin
    REF_CLK = 1'b0;
    forever #2 REF_CLK = ~REF_CLK;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict;
    if (n_fail == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    i_sru_host.xfer(1'b1, a, d, q, e);
    chk({31'h0, e}, {31'h0, ee});
  endtask

  task automatic rd(input logic [7:0] a);
    i_sru_host.xfer(1'b0, a, 32'h00000000, q, e);
  endtask

  // Full operation with both flag effects; busy must span the poll read
  task automatic run(input logic [5:0] op, input logic [31:0] dv, input logic [31:0] cnt,
                     input logic nr, input logic [31:0] res, input logic z, input logic c);
    wr(REG_DEST, dv, 1'b0);
    wr(REG_SRC, cnt, 1'b0);
    wr(REG_CTRL, 32'h80000600 | (32'(nr) << 11) | 32'(op), 1'b0);
    rd(REG_STATUS);
    chk({31'h0, q[ST_BUSY_BIT]}, 32'h1);
    rd(REG_STATUS);
    chk({31'h0, q[ST_BUSY_BIT]}, 32'h0);
    chk({30'h0, q[ST_CARRY_BIT], q[ST_ZERO_BIT]}, {30'h0, c, z});
    rd(REG_DEST);
    chk(q, nr ? dv : res);
    rd(REG_RESULT);
    chk(q, res);
  endtask

  // Hang guard, far beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge REF_CLK);
    n_fail++;
    give_verdict;
  end

  // Main sequence
  initial begin
    RST = 1'b1;
    CLK_EN = 1'b1;
    repeat (12) @(posedge REF_CLK);
    RST <= 1'b0;
    @(posedge REF_CLK);
    rd(REG_CTRL);
    chk(q, 32'h00000008);
    run(OP_ROT_LEFT, 32'h00000000, 32'h1, 1'b0, 32'h00000000, 1'b1, 1'b0);
    run(OP_ROT_LEFT, 32'h87654321, 32'h4, 1'b0, 32'h76543218, 1'b0, 1'b1);
    run(OP_ROT_RIGHT, 32'h81234567, 32'hC, 1'b0, 32'h56781234, 1'b0, 1'b1);
    run(OP_ROT_RIGHT, 32'h12345678, 32'h24, 1'b0, 32'h81234567, 1'b0, 1'b0);
    run(OP_ASH_RIGHT, 32'hFFFFFF9C, 32'h3, 1'b0, 32'hFFFFFFF3, 1'b0, 1'b0);
    run(OP_ASH_RIGHT, 32'hFFFFFFF3, 32'h1, 1'b0, 32'hFFFFFFF9, 1'b0, 1'b1);
    run(OP_ASH_RIGHT, 32'h00000006, 32'h3, 1'b0, 32'h00000000, 1'b1, 1'b0);
    run(OP_LSH_LEFT, 32'h87654321, 32'h4, 1'b0, 32'h76543210, 1'b0, 1'b1);
    run(OP_LSH_LEFT, 32'h43210000, 32'h10, 1'b0, 32'h00000000, 1'b1, 1'b0);
    run(OP_LSH_RIGHT, 32'h01234567, 32'hC, 1'b0, 32'h00001234, 1'b0, 1'b1);
    run(OP_LSH_RIGHT, 32'h12345678, 32'hFFFFFFE0, 1'b0, 32'h12345678, 1'b0, 1'b0);
    run(OP_ROT_LEFT, 32'h80000001, 32'h1, 1'b1, 32'h00000003, 1'b0, 1'b1);
    // Refused accesses and an undefined operation code
    wr(8'h14, 32'h00000001, 1'b1);
    wr(REG_RESULT, 32'h00000001, 1'b1);
    wr(REG_CTRL, 32'h8000063F, 1'b0);
    rd(REG_STATUS);
    rd(REG_STATUS);
    chk({31'h0, q[ST_BADOP_BIT]}, 32'h1);
    rd(REG_DEST);
    chk(q, 32'h80000001);
    // Effects off, enable frozen mid-operation, then a write refused while busy
    wr(REG_DEST, 32'h00000002, 1'b0);
    wr(REG_SRC, 32'h00000002, 1'b0);
    wr(REG_CTRL, 32'h8000000A, 1'b0);
    CLK_EN <= 1'b0;
    repeat (10) @(posedge REF_CLK);
    CLK_EN <= 1'b1;
    wr(REG_DEST, 32'hFFFFFFFF, 1'b1);
    rd(REG_STATUS);
    chk({27'h0, q[ST_BADOP_BIT:ST_BUSY_BIT]}, 32'h0000000C);
    rd(REG_DEST);
    chk(q, 32'h00000000);
    give_verdict;
  end
endmodule
